// >>> logic/ontime_defs.svh
`ifndef ONTIME_DEFS_SVH
`define ONTIME_DEFS_SVH

// Register offsets on the host register port.
`define OFS_CHAN1_HIGH 5'h05
`define OFS_CHAN1_MID 5'h06
`define OFS_CHAN3_HIGH 5'h09
`define OFS_CHAN3_MID 5'h0a
`define OFS_CHAN4_HIGH 5'h0b
`define OFS_CHAN4_MID 5'h0c
`define OFS_LOW_1_TO_4 5'h0d
`define OFS_CHAN5_HIGH 5'h0e
`define OFS_CHAN5_MID 5'h0f
`define OFS_CHAN6_HIGH 5'h10
`define OFS_CHAN6_MID 5'h11
`define OFS_LOW_5_6 5'h12

// Field positions.
`define POS_COMMON_SELECT 4
`define ONTIME_HIGH_MSB 17
`define ONTIME_HIGH_LSB 10
`define ONTIME_MID_MSB 9
`define ONTIME_MID_LSB 2

// Reset values.
`define RST_BYTE 8'hff
`define RST_LOW_FIELD 2'h3
`define RST_COMMON_SELECT 1'h0

// One count of on-time in nanoseconds, and clock period.
`define ONTIME_STEP_NS 50
`define CLOCK_PERIOD_NS 10
`define ONTIME_STEP_CYCLES (`ONTIME_STEP_NS / `CLOCK_PERIOD_NS)

`endif

// >>> logic/ontime_pkg.sv
package ontime_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] reg_addr_t;
  typedef logic [17:0] ontime_t;
  typedef logic [1:0] low_field_t;
endpackage

// >>> logic/ontime_select.sv
`timescale 1ns/1ps
`include "ontime_defs.svh"
// Chooses between a channel's own on-time and the common source value.
module ontime_select (
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire ontime_pkg::ontime_t own_value, // Channel's own value.
  input wire ontime_pkg::ontime_t common_value, // Channel 1 value.
  input wire logic common_ontime_select, // Use channel 1 value.
  input wire logic external_dimming_enable, // Dimming pin owns the channel.
  output ontime_pkg::ontime_t channel_on_time, // Registered on-time.
  output logic register_dimming // Registers govern dimming.
);
  ontime_pkg::ontime_t on_time_r;
  ontime_pkg::ontime_t on_time_nxt;
  logic reg_dim_r;
  logic reg_dim_nxt;

  always_comb begin
    on_time_nxt = common_ontime_select ? common_value : own_value;
    reg_dim_nxt = ~external_dimming_enable;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_time_r <= {`RST_BYTE, `RST_BYTE, `RST_LOW_FIELD};
      reg_dim_r <= 1'b0;
    end else begin
      on_time_r <= on_time_nxt;
      reg_dim_r <= reg_dim_nxt;
    end
  end

  assign channel_on_time = on_time_r;
  assign register_dimming = reg_dim_r;
endmodule

// >>> logic/led_channel_ontime_regs.sv
`timescale 1ns/1ps
`include "ontime_defs.svh"
module led_channel_ontime_regs (
  input wire logic clock, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire ontime_pkg::reg_addr_t reg_addr, // Register offset.
  input wire ontime_pkg::reg_byte_t reg_wdata, // Write data.
  input wire logic reg_write, // Write strobe, one cycle.
  input wire logic reg_read, // Read strobe, one cycle.
  input wire logic external_dimming_enable, // Dimming pin enable bit.
  output ontime_pkg::reg_byte_t reg_rdata, // Read data, registered.
  output logic reg_rvalid, // Read data valid pulse.
  output ontime_pkg::ontime_t chan1_on_time, // Channel 1 on-time.
  output ontime_pkg::ontime_t chan3_on_time, // Channel 3 on-time.
  output ontime_pkg::ontime_t chan4_on_time, // Channel 4 on-time.
  output ontime_pkg::ontime_t chan5_on_time, // Channel 5 on-time.
  output ontime_pkg::ontime_t chan6_on_time, // Channel 6 on-time.
  output logic register_dimming, // On-time registers govern dimming.
  output ontime_pkg::low_field_t chan2_ontime_low_field // Channel 2 low bits.
);
  // Index 0..4 is channel 1,3,4,5,6; arrays keep the decode compact.
  ontime_pkg::reg_byte_t high_r [0:4];
  ontime_pkg::reg_byte_t high_nxt [0:4];
  ontime_pkg::reg_byte_t mid_r [0:4];
  ontime_pkg::reg_byte_t mid_nxt [0:4];
  ontime_pkg::reg_byte_t low14_r;
  ontime_pkg::reg_byte_t low14_nxt;
  ontime_pkg::low_field_t low5_r;
  ontime_pkg::low_field_t low5_nxt;
  ontime_pkg::low_field_t low6_r;
  ontime_pkg::low_field_t low6_nxt;
  logic common_ontime_select_r;
  logic common_ontime_select_nxt;
  ontime_pkg::reg_byte_t rdata_r;
  ontime_pkg::reg_byte_t rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  ontime_pkg::ontime_t own [0:4];
  ontime_pkg::ontime_t sel [0:4];
  logic reg_dim [0:4];

  // Slot of a high byte offset, or 3'h7 when none.
  function automatic logic [2:0] high_slot(input ontime_pkg::reg_addr_t a);
    if (a == `OFS_CHAN1_HIGH) high_slot = 3'h0;
    else if (a == `OFS_CHAN3_HIGH) high_slot = 3'h1;
    else if (a == `OFS_CHAN4_HIGH) high_slot = 3'h2;
    else if (a == `OFS_CHAN5_HIGH) high_slot = 3'h3;
    else if (a == `OFS_CHAN6_HIGH) high_slot = 3'h4;
    else high_slot = 3'h7;
  endfunction

  function automatic logic [2:0] mid_slot(input ontime_pkg::reg_addr_t a);
    if (a == `OFS_CHAN1_MID) mid_slot = 3'h0;
    else if (a == `OFS_CHAN3_MID) mid_slot = 3'h1;
    else if (a == `OFS_CHAN4_MID) mid_slot = 3'h2;
    else if (a == `OFS_CHAN5_MID) mid_slot = 3'h3;
    else if (a == `OFS_CHAN6_MID) mid_slot = 3'h4;
    else mid_slot = 3'h7;
  endfunction

  function automatic ontime_pkg::ontime_t pack(input ontime_pkg::reg_byte_t h,
      input ontime_pkg::reg_byte_t m, input ontime_pkg::low_field_t l);
    pack = {h, m, l};
  endfunction

  logic [2:0] hs;
  logic [2:0] ms;
  assign hs = high_slot(reg_addr);
  assign ms = mid_slot(reg_addr);

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      high_nxt[i] = high_r[i];
      mid_nxt[i] = mid_r[i];
    end
    low14_nxt = low14_r;
    low5_nxt = low5_r;
    low6_nxt = low6_r;
    common_ontime_select_nxt = common_ontime_select_r;
    if (reg_write) begin
      if (hs != 3'h7) begin
        high_nxt[hs] = reg_wdata;
      end else if (ms != 3'h7) begin
        mid_nxt[ms] = reg_wdata;
      end else if (reg_addr == `OFS_LOW_1_TO_4) begin
        low14_nxt = reg_wdata;
      end else if (reg_addr == `OFS_LOW_5_6) begin
        // channel 5 and 6 low fields
        low5_nxt = reg_wdata[1:0];
        low6_nxt = reg_wdata[3:2];
        common_ontime_select_nxt = reg_wdata[`POS_COMMON_SELECT];
      end
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_read;
    if (reg_read) begin
      if (hs != 3'h7) begin
        rdata_nxt = high_r[hs];
      end else if (ms != 3'h7) begin
        rdata_nxt = mid_r[ms];
      end else if (reg_addr == `OFS_LOW_1_TO_4) begin
        rdata_nxt = low14_r;
      end else if (reg_addr == `OFS_LOW_5_6) begin
        rdata_nxt = {3'h0, common_ontime_select_r, low6_r, low5_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        high_r[i] <= `RST_BYTE;
        mid_r[i] <= `RST_BYTE;
      end
      low14_r <= `RST_BYTE;
      low5_r <= `RST_LOW_FIELD;
      low6_r <= `RST_LOW_FIELD;
      common_ontime_select_r <= `RST_COMMON_SELECT;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        high_r[i] <= high_nxt[i];
        mid_r[i] <= mid_nxt[i];
      end
      low14_r <= low14_nxt;
      low5_r <= low5_nxt;
      low6_r <= low6_nxt;
      common_ontime_select_r <= common_ontime_select_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_comb begin
    own[0] = pack(high_r[0], mid_r[0], low14_r[1:0]);
    own[1] = pack(high_r[1], mid_r[1], low14_r[5:4]);
    own[2] = pack(high_r[2], mid_r[2], low14_r[7:6]);
    own[3] = pack(high_r[3], mid_r[3], low5_r);
    own[4] = pack(high_r[4], mid_r[4], low6_r);
  end

  // Channel 1 is its own source, so the option leaves it unchanged.
  for (genvar g = 0; g < 5; g++) begin : g_sel
    ontime_select u_sel (
      .clock(clock),
      .rst(rst),
      .own_value(own[g]),
      .common_value(own[0]),
      .common_ontime_select(common_ontime_select_r),
      .external_dimming_enable(external_dimming_enable),
      .channel_on_time(sel[g]),
      .register_dimming(reg_dim[g])
    );
  end

  // Channel 2 low field lives here; its bytes are held elsewhere.
  ontime_pkg::low_field_t chan2_low_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan2_low_r <= `RST_LOW_FIELD;
    end else begin
      chan2_low_r <= low14_nxt[3:2];
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign chan1_on_time = sel[0];
  assign chan3_on_time = sel[1];
  assign chan4_on_time = sel[2];
  assign chan5_on_time = sel[3];
  assign chan6_on_time = sel[4];
  assign register_dimming = reg_dim[0];
  assign chan2_ontime_low_field = chan2_low_r;
endmodule

// >>> testbench/ontime_checker.sv
`timescale 1ns/1ps
module ontime_checker (
  input wire logic clock, // System clock.
  input wire logic rst, // Reset.
  input wire ontime_pkg::reg_addr_t reg_addr, // Offset.
  input wire ontime_pkg::reg_byte_t reg_wdata, // Write data.
  input wire logic reg_write, // Write strobe.
  input wire logic reg_read, // Read strobe.
  input wire logic external_dimming_enable, // Dimming pin bit.
  input wire ontime_pkg::reg_byte_t reg_rdata, // Read data.
  input wire logic reg_rvalid, // Read valid.
  input wire ontime_pkg::ontime_t chan1_on_time, // Channel 1.
  input wire ontime_pkg::ontime_t chan3_on_time, // Channel 3.
  input wire ontime_pkg::ontime_t chan6_on_time, // Channel 6.
  input wire logic register_dimming, // Registers govern.
  input wire ontime_pkg::low_field_t chan2_ontime_low_field // Channel 2 low.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr(a);
    reg_write && reg_addr == a;
  endsequence
  // A quiet cycle after the write keeps the checked output free of a later write.
  sequence s_wr_alone(a);
    s_wr(a) ##1 !reg_write;
  endsequence
  property p_rd; reg_read |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_hi3; s_wr_alone(5'h09) |=> chan3_on_time[17:10] == $past(reg_wdata, 2)
    || chan3_on_time == chan1_on_time; endproperty
  a_hi3: assert property (p_hi3) else $error("channel 3 high byte");
  property p_mid6; s_wr_alone(5'h11) |=> chan6_on_time[9:2] == $past(reg_wdata, 2)
    || chan6_on_time == chan1_on_time; endproperty
  a_mid6: assert property (p_mid6) else $error("channel 6 mid byte");
  property p_low2; s_wr_alone(5'h0d) |=> chan2_ontime_low_field == $past(reg_wdata[3:2], 2);
  endproperty
  a_low2: assert property (p_low2) else $error("channel 2 low field");
  property p_all; s_wr(5'h12) ##0 reg_wdata[4] ##1 !reg_write |=>
    chan3_on_time == chan1_on_time && chan6_on_time == chan1_on_time; endproperty
  a_all: assert property (p_all) else $error("common value not used");
  property p_top; reg_read && reg_addr == 5'h12 |=> reg_rdata[7:5] == 3'h0; endproperty
  a_top: assert property (p_top) else $error("unused bits set");
  property p_dim; !$past(rst) |-> register_dimming == !$past(external_dimming_enable);
  endproperty
  a_dim: assert property (p_dim) else $error("dimming owner wrong");
endmodule
bind led_channel_ontime_regs ontime_checker u_chk (.*);

// >>> testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clock, // System clock.
  output ontime_pkg::reg_addr_t reg_addr, // Offset.
  output ontime_pkg::reg_byte_t reg_wdata, // Write data.
  output logic reg_write, // Write strobe.
  output logic reg_read // Read strobe.
);
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Released lines show the inverse so that stale values are never mistaken for valid ones.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
    reg_addr <= ~a;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// >>> testbench/led_channel_ontime_regs_tb.sv
`timescale 1ns/1ps
module led_channel_ontime_regs_tb;
  logic clock, rst, ext, wr_s, rd_s, rvalid, regdim;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, w;
  logic [1:0] c2lo;
  logic [17:0] ot[5];
  logic [7:0] hi[5], md[5], exp_q[$];
  logic [1:0] lo[6];
  logic [4:0] ha[5] = '{5'h05, 5'h09, 5'h0b, 5'h0e, 5'h10};
  int li[5] = '{0, 2, 3, 4, 5};
  int errors = 0, check_count = 0, seed = 32'h1e92f7a3;
  host_model host (.clock(clock), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
    .reg_read(rd_s));
  led_channel_ontime_regs DUT (.clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_s), .reg_read(rd_s), .external_dimming_enable(ext), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .chan1_on_time(ot[0]), .chan3_on_time(ot[1]), .chan4_on_time(ot[2]),
    .chan5_on_time(ot[3]), .chan6_on_time(ot[4]), .register_dimming(regdim),
    .chan2_ontime_low_field(c2lo));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rdx(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic chan_all(input logic com);
    for (int k = 0; k < 5; k++) begin
      chk("on_time", com ? {hi[0], md[0], lo[0]} : {hi[k], md[k], lo[li[k]]}, ot[k]);
    end
  endtask
  task automatic read_all(input logic com);
    for (int k = 0; k < 5; k++) begin
      rdx(ha[k], hi[k]);
      rdx(ha[k] + 5'h01, md[k]);
    end
    rdx(5'h0d, {lo[3], lo[2], lo[1], lo[0]});
    rdx(5'h12, {3'h0, com, lo[5], lo[4]});
  endtask
  // Each read answer is matched against the oldest expectation noted by the driver.
  always @(posedge clock) begin
    if (rvalid === 1'b1) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end
  initial begin
    rst = 1'b1;
    ext = 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    hi = '{5{8'hff}};
    md = '{5{8'hff}};
    lo = '{6{2'h3}};
    read_all(1'b0);
    chan_all(1'b0);
    for (int k = 0; k < 5; k++) begin
      hi[k] = $random(seed);
      md[k] = $random(seed);
      host.wr(ha[k], hi[k]);
      host.wr(ha[k] + 5'h01, md[k]);
    end
    w = $random(seed);
    host.wr(5'h0d, w);
    {lo[3], lo[2], lo[1], lo[0]} = w;
    w = $random(seed);
    w = (w | 8'he0) & 8'hef;
    host.wr(5'h12, w);
    {lo[5], lo[4]} = w[3:0];
    repeat (2) @(posedge clock);
    chan_all(1'b0);
    chk("chan2 low", lo[1], c2lo);
    read_all(1'b0);
    host.wr(5'h12, w | 8'h10);
    repeat (2) @(posedge clock);
    chan_all(1'b1);
    host.wr(5'h1f, 8'h00);
    rdx(5'h1f, 8'h00);
    rdx(5'h00, 8'h00);
    read_all(1'b1);
    ext <= 1'b1;
    repeat (3) @(posedge clock);
    chk("dimming", 18'h0, regdim);
    ext <= 1'b0;
    repeat (3) @(posedge clock);
    chk("dimming", 18'h1, regdim);
    // A second reset in mid-run must bring back every reset value.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    hi = '{5{8'hff}};
    md = '{5{8'hff}};
    lo = '{6{2'h3}};
    read_all(1'b0);
    chan_all(1'b0);
    repeat (3) @(posedge clock);
    chk("chan2 low", lo[1], c2lo);
    chk("pending reads", 18'h0, exp_q.size());
    tally_and_finish();
  end
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule
